// ===== hdl/gcp_global_config.sv
// Purpose: global configuration indices 27h..2Bh and their pin effects
// Assumes: host index/data cycles arrive synchronous to clk_sys_in
// Notes:   flash clock field on standby reset, read mode on battery reset
`timescale 1ns/10ps
`include "gcp_params.svh"
module gcp_global_config (
  // clock and resets
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire logic               rst_stby_n_in,
  input  wire logic               rst_bat_n_in,
  // configuration index/data access
  input  wire logic               cfg_rd_in,
  input  wire logic               cfg_wr_in,
  input  wire gcp_pkg::gcp_byte_type cfg_index_in,
  input  wire gcp_pkg::gcp_byte_type cfg_wdata_in,
  output gcp_pkg::gcp_byte_type   cfg_rdata_out,
  output logic                    cfg_rvalid_out,
  // neighbouring configuration bits
  input  wire logic               config_write_lock_in,
  input  wire logic               reset_output_three_sel_in,
  input  wire logic               reset_output_two_sel_in,
  // pins
  input  wire logic               flash_interface_strap_enable_in,
  input  wire logic               i2c_data_pin_in,
  input  wire logic               i2c_clock_pin_in,
  // decode and mode
  output logic                    bios_e_decode_en_out,
  output logic [2:0]              parallel_mode_code_out,
  output logic                    parallel_mode_valid_out,
  // pin function selects
  output logic                    uart_a_pins_gpio_out,
  output logic                    fan_pins_gpio_out,
  output logic                    i2c_pins_active_out,
  output logic                    reset_output_three_en_out,
  output logic                    reset_output_two_en_out,
  output logic                    kbms_pins_gpio_out,
  // serial flash read setup
  output logic                    flash_if_enable_out,
  output logic [1:0]              flash_clk_code_out,
  output logic                    flash_fast_read_out,
  output logic [2:0]              flash_read_bytes_out,
  // filtered I2C inputs
  output logic                    i2c_data_filt_out,
  output logic                    i2c_clock_filt_out
);
  import gcp_pkg::*;

  gcp_byte_type        rom_par_r;
  gcp_byte_type        pin_sel_a_r;
  logic [3:0]          flash_i2c_lo_r;
  logic [1:0]          flash_mode_r;
  logic [1:0]          flash_clk_r;
  gcp_byte_type        rom_par_nxt;
  gcp_byte_type        pin_sel_a_nxt;
  gcp_byte_type        flash_i2c_nxt;
  gcp_byte_type        flash_i2c_cur;
  logic                access_ok;
  gcp_strap_state_type strap_st_r;
  gcp_strap_state_type strap_st_nxt;
  logic [2:0]          settle_r;
  logic [2:0]          settle_nxt;
  logic                flash_en_r;
  logic                flash_en_nxt;
  logic                strap_lvl;
  logic                sda_sync;
  logic                scl_sync;
  gcp_byte_type        rdata_r;
  gcp_byte_type        rdata_nxt;
  logic                rvalid_r;
  logic                rvalid_nxt;
  logic [18:0]         out_r;
  logic [18:0]         out_nxt;

  // masked read view of one index
  function automatic gcp_byte_type read_index(input gcp_byte_type idx,
                                              input gcp_byte_type r28,
                                              input gcp_byte_type r29,
                                              input gcp_byte_type r2a);
    gcp_byte_type val;
    val = 8'h00;
    case (idx)
      `GCP_IDX_ROM_PAR:   val = r28 & `GCP_MASK_ROM_PAR;
      `GCP_IDX_PIN_SEL_A: val = r29 & `GCP_MASK_PIN_SEL_A;
      `GCP_IDX_FLASH_I2C: val = r2a & `GCP_MASK_FLASH_I2C;
      default:            val = 8'h00; // reserved 27h, 2Bh, others
    endcase
    return val;
  endfunction

  // pin synchronisers; I2C lines ride inverted so reset reads as idle high
  gcp_sync3 u_strap_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (flash_interface_strap_enable_in),
    .level_out  (strap_lvl)
  );
  gcp_sync3 u_sda_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (!i2c_data_pin_in),
    .level_out  (sda_sync)
  );
  gcp_sync3 u_scl_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (!i2c_clock_pin_in),
    .level_out  (scl_sync)
  );

  // I2C input filters with bypass bits
  gcp_input_filter u_sda_filter (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .bypass_in  (flash_i2c_lo_r[`GCP_BIT_SDA_BYPASS]), // RQ11
    .level_in   (!sda_sync),
    .level_out  (i2c_data_filt_out)
  );
  gcp_input_filter u_scl_filter (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .bypass_in  (flash_i2c_lo_r[`GCP_BIT_SCL_BYPASS]), // RQ12
    .level_in   (!scl_sync),
    .level_out  (i2c_clock_filt_out)
  );

  // strap capture once the synchroniser has settled after reset
  always_comb begin
    strap_st_nxt = strap_st_r;
    settle_nxt   = settle_r;
    flash_en_nxt = flash_en_r;
    case (strap_st_r)
      GCP_STRAP_WAIT: begin
        settle_nxt = settle_r + 3'h1;
        if (settle_r == `GCP_STRAP_SETTLE) begin
          flash_en_nxt = strap_lvl; // RQ16
          strap_st_nxt = GCP_STRAP_HELD;
        end
      end
      GCP_STRAP_HELD: strap_st_nxt = GCP_STRAP_HELD;
      default:        strap_st_nxt = GCP_STRAP_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_st_r <= GCP_STRAP_WAIT;
      settle_r   <= 3'h0;
      flash_en_r <= 1'b0;
    end else begin
      strap_st_r <= strap_st_nxt;
      settle_r   <= settle_nxt;
      flash_en_r <= flash_en_nxt;
    end
  end

  // register writes and reads, both blocked by the lock
  always_comb begin
    access_ok     = !config_write_lock_in; // RQ18
    flash_i2c_cur = {flash_clk_r, flash_mode_r, flash_i2c_lo_r};
    rom_par_nxt   = rom_par_r;
    pin_sel_a_nxt = pin_sel_a_r;
    flash_i2c_nxt = flash_i2c_cur;
    if (cfg_wr_in && access_ok) begin
      case (cfg_index_in)
        `GCP_IDX_ROM_PAR:   rom_par_nxt = cfg_wdata_in & `GCP_MASK_ROM_PAR;
        `GCP_IDX_PIN_SEL_A:
          pin_sel_a_nxt = cfg_wdata_in & `GCP_MASK_PIN_SEL_A;
        `GCP_IDX_FLASH_I2C: flash_i2c_nxt = cfg_wdata_in;
        default: ; // RQ19
      endcase
    end
    rvalid_nxt = cfg_rd_in;
    rdata_nxt  = 8'h00;
    if (cfg_rd_in && access_ok) begin
      rdata_nxt = read_index(cfg_index_in, rom_par_r, pin_sel_a_r,
                             flash_i2c_cur); // RQ19
    end
  end

  // main-power registers and read data
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rom_par_r      <= `GCP_RST_ROM_PAR; // RQ20
      pin_sel_a_r    <= `GCP_RST_PIN_SEL_A;
      flash_i2c_lo_r <= 4'h0;
      rdata_r        <= 8'h00;
      rvalid_r       <= 1'b0;
    end else begin
      rom_par_r      <= rom_par_nxt;
      pin_sel_a_r    <= pin_sel_a_nxt;
      flash_i2c_lo_r <= flash_i2c_nxt[3:0];
      rdata_r        <= rdata_nxt;
      rvalid_r       <= rvalid_nxt;
    end
  end

  // flash clock field lives on the standby well
  always_ff @(posedge clk_sys_in or negedge rst_stby_n_in) begin
    if (!rst_stby_n_in) begin
      flash_clk_r <= 2'h0; // RQ15
    end else begin
      flash_clk_r <= flash_i2c_nxt[7:6];
    end
  end

  // read-mode field lives on the battery well
  always_ff @(posedge clk_sys_in or negedge rst_bat_n_in) begin
    if (!rst_bat_n_in) begin
      flash_mode_r <= 2'h0; // RQ15
    end else begin
      flash_mode_r <= flash_i2c_nxt[5:4];
    end
  end

  // pin and flash effects, all registered before they leave
  always_comb begin
    out_nxt     = 19'h0;
    out_nxt[0]  = !rom_par_r[`GCP_BIT_E_DECODE_DIS]; // RQ1
    out_nxt[3:1] = rom_par_r[2:0]; // RQ2
    out_nxt[4]  = !rom_par_r[2]; // RQ2
    out_nxt[5]  = pin_sel_a_r[`GCP_BIT_UART_A_GPIO]; // RQ3
    out_nxt[6]  = (pin_sel_a_r[2:1] == `GCP_FAN_GPIO); // RQ4
    out_nxt[7]  = flash_i2c_lo_r[`GCP_BIT_I2C_PINS]; // RQ13
    out_nxt[8]  = !flash_i2c_lo_r[`GCP_BIT_I2C_PINS] &&
                  reset_output_three_sel_in; // RQ17
    out_nxt[9]  = !flash_i2c_lo_r[`GCP_BIT_I2C_PINS] &&
                  reset_output_two_sel_in; // RQ17
    out_nxt[10] = flash_i2c_lo_r[`GCP_BIT_KBMS_GPIO]; // RQ14
    out_nxt[11] = flash_en_r; // RQ16
    // defaults while disabled: 16 MHz normal one-byte reads
    out_nxt[13:12] = `GCP_CLK_16MHZ; // RQ6
    out_nxt[14]    = 1'b0;
    out_nxt[17:15] = `GCP_BYTES_NORMAL; // RQ10
    if (flash_en_r) begin
      if (flash_mode_r == `GCP_MODE_FAST) begin
        out_nxt[13:12] = `GCP_CLK_33MHZ; // RQ8
        out_nxt[14]    = 1'b1;
        out_nxt[17:15] = `GCP_BYTES_FAST; // RQ10
      end else begin
        out_nxt[13:12] = flash_clk_r; // RQ5 RQ7
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_r <= 19'h08010; // decode off for 50h, mode valid, one byte
    end else begin
      out_r <= out_nxt;
    end
  end

  assign bios_e_decode_en_out      = out_r[0];
  assign parallel_mode_code_out    = out_r[3:1];
  assign parallel_mode_valid_out   = out_r[4];
  assign uart_a_pins_gpio_out      = out_r[5];
  assign fan_pins_gpio_out         = out_r[6];
  assign i2c_pins_active_out       = out_r[7];
  assign reset_output_three_en_out = out_r[8];
  assign reset_output_two_en_out   = out_r[9];
  assign kbms_pins_gpio_out        = out_r[10];
  assign flash_if_enable_out       = out_r[11];
  assign flash_clk_code_out        = out_r[13:12];
  assign flash_fast_read_out       = out_r[14];
  assign flash_read_bytes_out      = out_r[17:15];
  assign cfg_rdata_out             = rdata_r;
  assign cfg_rvalid_out            = rvalid_r;

  // checks
  bios_decode_a: assert property ( // RQ1
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (cfg_wr_in && !config_write_lock_in &&
     cfg_index_in == `GCP_IDX_ROM_PAR) ##1
    !(cfg_wr_in && cfg_index_in == `GCP_IDX_ROM_PAR)
    |=> (bios_e_decode_en_out == !$past(cfg_wdata_in[4], 2)))
    else $error("bios decode enable does not follow written bit");

  par_mode_a: assert property ( // RQ2
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    parallel_mode_valid_out == !$past(rom_par_r[2]))
    else $error("parallel mode valid disagrees with code");

  fan_pins_a: assert property ( // RQ4
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    fan_pins_gpio_out |-> $past(pin_sel_a_r[2:1]) == `GCP_FAN_GPIO)
    else $error("fan pins gpio without code 01");

  flash_off_a: assert property ( // RQ6
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !flash_if_enable_out |-> !flash_fast_read_out &&
      flash_clk_code_out == `GCP_CLK_16MHZ)
    else $error("flash setup active while interface disabled");

  fast_read_a: assert property ( // RQ8
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    flash_fast_read_out |-> flash_clk_code_out == `GCP_CLK_33MHZ &&
      flash_read_bytes_out == `GCP_BYTES_FAST)
    else $error("fast read not at 33 MHz with four bytes");

  read_len_a: assert property ( // RQ10
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !flash_fast_read_out |-> flash_read_bytes_out == `GCP_BYTES_NORMAL)
    else $error("normal read length not one byte");

  i2c_pins_a: assert property ( // RQ17
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    i2c_pins_active_out |-> !reset_output_three_en_out &&
      !reset_output_two_en_out)
    else $error("reset outputs enabled while pins are I2C");

  lock_read_a: assert property ( // RQ18
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    cfg_rd_in && config_write_lock_in |=>
      cfg_rvalid_out && cfg_rdata_out == 8'h00)
    else $error("locked read returned data");

  lock_write_a: assert property ( // RQ18
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    cfg_wr_in && config_write_lock_in |=> $stable(rom_par_r) &&
      $stable(pin_sel_a_r) && $stable(flash_i2c_lo_r))
    else $error("locked write changed a register");

  rsvd_read_a: assert property ( // RQ19
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    cfg_rd_in && (cfg_index_in == `GCP_IDX_RSVD_27 ||
      cfg_index_in == `GCP_IDX_RSVD_2B) |=> cfg_rdata_out == 8'h00)
    else $error("reserved index read nonzero");
endmodule

// ===== hdl/gcp_input_filter.sv
// Purpose: glitch filter for one synchronised I2C line, with bypass
// Assumes: level_in already on clk_sys_in
// Notes:   filtered level follows after a run of equal samples
`timescale 1ns/10ps
`include "gcp_params.svh"
module gcp_input_filter (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic bypass_in,
  // data
  input  wire logic level_in,
  output logic      level_out
);
  logic [2:0] run_r;
  logic [2:0] run_nxt;
  logic       out_r;
  logic       out_nxt;

  // count samples that differ from the output; bypass passes through
  always_comb begin
    run_nxt = 3'h0;
    out_nxt = out_r;
    if (bypass_in) begin
      out_nxt = level_in;
    end else if (level_in != out_r) begin
      run_nxt = run_r + 3'h1;
      if (run_nxt == `GCP_FILTER_CYCLES) begin
        out_nxt = level_in;
        run_nxt = 3'h0;
      end
    end
  end

  // register count and output
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_r <= 3'h0;
      out_r <= 1'b1;
    end else begin
      run_r <= run_nxt;
      out_r <= out_nxt;
    end
  end

  assign level_out = out_r;
endmodule

// ===== hdl/gcp_sync3.sv
// Purpose: three-stage synchroniser for one pin level
// Assumes: pin is asynchronous to clk_sys_in
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
module gcp_sync3 (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // pin and clean level
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       level_r;
  logic       level_nxt;

  // shift chain; first stage feeds only the second
  always_comb begin
    stage_nxt = {stage_r[1:0], pin_in};
    level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
  end

  // register the chain and the agreed level
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule

// ===== include/gcp_params.svh
// Purpose: constants for the global configuration pin select block
// Assumes: one register clock, host reaches indices through index/data
// Notes:   offsets are configuration indices, not byte addresses
//
// What this block does
// (RQ1) bit 4 of 28h clear enables E-segment decode
// (RQ2) parallel mode code top bit zero, others reserved
// (RQ3) 29h bit 3 moves serial A pins to GPIO
// (RQ4) 29h bits 2:1 pick fan or GPIO pins
// (RQ5) 2Ah bits 7:6 pick normal read clock
// (RQ6) flash fields ignored while flash interface disabled
// (RQ7) read mode 00 gives normal read at chosen clock
// (RQ8) read mode 11 gives fast read at 33 MHz
// (RQ9) software keeps clock field zero with fast read
// (RQ10) normal read one byte, fast read four bytes
// (RQ11) 2Ah bit 3 bypasses I2C data filter
// (RQ12) 2Ah bit 2 bypasses I2C clock filter
// (RQ13) 2Ah bit 1 gives shared pins to I2C
// (RQ14) 2Ah bit 0 turns keyboard/mouse pins to GPIO
// (RQ15) clock field on standby, read mode on battery
// (RQ16) flash enable taken from strap after reset
// (RQ17) 2Ch pin selects ignored while I2C pins active
// (RQ18) lock bit blocks configuration reads and writes
// (RQ19) reserved indices and bits read zero
// (RQ20) reset values 50h, 00h, 00h; wells keep bits
`ifndef GCP_PARAMS_SVH
`define GCP_PARAMS_SVH

`define GCP_IDX_RSVD_27     8'h27
`define GCP_IDX_ROM_PAR     8'h28
`define GCP_IDX_PIN_SEL_A   8'h29
`define GCP_IDX_FLASH_I2C   8'h2a
`define GCP_IDX_RSVD_2B     8'h2b

`define GCP_RST_ROM_PAR     8'h50
`define GCP_RST_PIN_SEL_A   8'h00
`define GCP_RST_FLASH_I2C   8'h00

`define GCP_MASK_ROM_PAR    8'h7f
`define GCP_MASK_PIN_SEL_A  8'h4e
`define GCP_MASK_FLASH_I2C  8'hff

`define GCP_BIT_E_DECODE_DIS 4
`define GCP_BIT_UART_A_GPIO  3
`define GCP_BIT_SDA_BYPASS   3
`define GCP_BIT_SCL_BYPASS   2
`define GCP_BIT_I2C_PINS     1
`define GCP_BIT_KBMS_GPIO    0

`define GCP_CLK_16MHZ       2'h0
`define GCP_CLK_33MHZ       2'h1
`define GCP_CLK_22MHZ       2'h2
`define GCP_MODE_NORMAL     2'h0
`define GCP_MODE_FAST       2'h3
`define GCP_FAN_GPIO        2'h1
`define GCP_BYTES_NORMAL    3'h1
`define GCP_BYTES_FAST      3'h4

`define GCP_FILTER_CYCLES   3'h4
`define GCP_STRAP_SETTLE    3'h5

`endif

// ===== include/gcp_pkg.sv
// Purpose: shared types of the global configuration pin select block
// Assumes: constants live in gcp_params.svh
// Notes:   none
package gcp_pkg;
  typedef logic [7:0] gcp_byte_type;
  typedef enum logic [0:0] {
    GCP_STRAP_WAIT,
    GCP_STRAP_HELD
  } gcp_strap_state_type;
endpackage

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the global configuration pin select
// Assumes: index/data strobes driven on the falling clock edge
// Notes:   expected values come from the register table and pin rules
`timescale 1ns/10ps
`include "gcp_params.svh"

`define CHK(got, exp) \
  begin \
    n_compared = n_compared + 1; \
    if ((got) !== (exp)) begin \
      err_total = err_total + 1; \
      $display("mismatch at %0t got %h exp %h", $time, got, exp); \
    end \
  end

module tb_top;
  import gcp_pkg::*;

  logic         clk_sys_in;
  logic         rst_n_in;
  logic         rst_stby_n_in;
  logic         rst_bat_n_in;
  logic         cfg_rd_in;
  logic         cfg_wr_in;
  gcp_byte_type cfg_index_in;
  gcp_byte_type cfg_wdata_in;
  gcp_byte_type cfg_rdata_out;
  logic         cfg_rvalid_out;
  logic         config_write_lock_in;
  logic         reset_output_three_sel_in;
  logic         reset_output_two_sel_in;
  logic         flash_interface_strap_enable_in;
  logic         i2c_data_pin_in;
  logic         i2c_clock_pin_in;
  logic         bios_e_decode_en_out;
  logic [2:0]   parallel_mode_code_out;
  logic         parallel_mode_valid_out;
  logic         uart_a_pins_gpio_out;
  logic         fan_pins_gpio_out;
  logic         i2c_pins_active_out;
  logic         reset_output_three_en_out;
  logic         reset_output_two_en_out;
  logic         kbms_pins_gpio_out;
  logic         flash_if_enable_out;
  logic [1:0]   flash_clk_code_out;
  logic         flash_fast_read_out;
  logic [2:0]   flash_read_bytes_out;
  logic         i2c_data_filt_out;
  logic         i2c_clock_filt_out;
  int           err_total;
  int           n_compared;
  logic         hit;

  gcp_global_config u_dut (
    .clk_sys_in                      (clk_sys_in),
    .rst_n_in                        (rst_n_in),
    .rst_stby_n_in                   (rst_stby_n_in),
    .rst_bat_n_in                    (rst_bat_n_in),
    .cfg_rd_in                       (cfg_rd_in),
    .cfg_wr_in                       (cfg_wr_in),
    .cfg_index_in                    (cfg_index_in),
    .cfg_wdata_in                    (cfg_wdata_in),
    .cfg_rdata_out                   (cfg_rdata_out),
    .cfg_rvalid_out                  (cfg_rvalid_out),
    .config_write_lock_in            (config_write_lock_in),
    .reset_output_three_sel_in       (reset_output_three_sel_in),
    .reset_output_two_sel_in         (reset_output_two_sel_in),
    .flash_interface_strap_enable_in (flash_interface_strap_enable_in),
    .i2c_data_pin_in                 (i2c_data_pin_in),
    .i2c_clock_pin_in                (i2c_clock_pin_in),
    .bios_e_decode_en_out            (bios_e_decode_en_out),
    .parallel_mode_code_out          (parallel_mode_code_out),
    .parallel_mode_valid_out         (parallel_mode_valid_out),
    .uart_a_pins_gpio_out            (uart_a_pins_gpio_out),
    .fan_pins_gpio_out               (fan_pins_gpio_out),
    .i2c_pins_active_out             (i2c_pins_active_out),
    .reset_output_three_en_out       (reset_output_three_en_out),
    .reset_output_two_en_out         (reset_output_two_en_out),
    .kbms_pins_gpio_out              (kbms_pins_gpio_out),
    .flash_if_enable_out             (flash_if_enable_out),
    .flash_clk_code_out              (flash_clk_code_out),
    .flash_fast_read_out             (flash_fast_read_out),
    .flash_read_bytes_out            (flash_read_bytes_out),
    .i2c_data_filt_out               (i2c_data_filt_out),
    .i2c_clock_filt_out              (i2c_clock_filt_out)
  );

  // 20 MHz system clock
  initial clk_sys_in = 1'b0;
  always #25 clk_sys_in = ~clk_sys_in;

  // verdict and end of run
  task finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // pulse the chosen resets: bit0 hardware, bit1 standby, bit2 battery
  task do_reset(input logic [2:0] which);
    @(negedge clk_sys_in);
    rst_n_in      = ~which[0];
    rst_stby_n_in = ~which[1];
    rst_bat_n_in  = ~which[2];
    repeat (10) @(negedge clk_sys_in);
    rst_n_in      = 1'b1;
    rst_stby_n_in = 1'b1;
    rst_bat_n_in  = 1'b1;
    repeat (8) @(negedge clk_sys_in); // strap capture settles
  endtask

  // one write; dependent outputs settle one edge after the take
  task wr_reg(input gcp_byte_type idx, input gcp_byte_type dat);
    @(negedge clk_sys_in);
    cfg_wr_in    = 1'b1;
    cfg_index_in = idx;
    cfg_wdata_in = dat;
    @(negedge clk_sys_in);
    cfg_wr_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask

  // one read; answer stands for the cycle after the take
  task rd_chk(input gcp_byte_type idx, input gcp_byte_type exp);
    @(negedge clk_sys_in);
    cfg_rd_in    = 1'b1;
    cfg_index_in = idx;
    @(negedge clk_sys_in);
    cfg_rd_in = 1'b0;
    `CHK(cfg_rvalid_out, 1'b1)
    `CHK(cfg_rdata_out, exp)
  endtask

  // drive one I2C pin
  task set_pin(input int s, input logic v);
    if (s == 0) begin
      i2c_data_pin_in = v;
    end else begin
      i2c_clock_pin_in = v;
    end
  endtask

  // low pulse of len cycles on a pin; hit when filtered level went low
  task probe(input int s, input int len, input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys_in);
      if (i == 0) set_pin(s, 1'b0);
      if (i == len) set_pin(s, 1'b1);
      if (s == 0 && i2c_data_filt_out === 1'b0) seen = 1'b1;
      if (s == 1 && i2c_clock_filt_out === 1'b0) seen = 1'b1;
    end
    repeat (12) @(negedge clk_sys_in); // let the filter recover
  endtask

  // watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total = err_total + 1;
    finish_test();
  end

  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    rst_n_in = 1'b0;
    rst_stby_n_in = 1'b0;
    rst_bat_n_in = 1'b0;
    cfg_rd_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_index_in = 8'h00;
    cfg_wdata_in = 8'h00;
    config_write_lock_in = 1'b0;
    reset_output_three_sel_in = 1'b1;
    reset_output_two_sel_in = 1'b1;
    flash_interface_strap_enable_in = 1'b0;
    i2c_data_pin_in = 1'b1;
    i2c_clock_pin_in = 1'b1;
    // strap low, then high, across hardware resets
    do_reset(3'h7);
    `CHK(flash_if_enable_out, 1'b0)
    wr_reg(8'h2a, 8'h40);
    `CHK(flash_clk_code_out, 2'h0)
    flash_interface_strap_enable_in = 1'b1;
    do_reset(3'h7);
    `CHK(flash_if_enable_out, 1'b1)
    // reset values, reserved and undecoded indices
    rd_chk(8'h27, 8'h00);
    rd_chk(8'h28, 8'h50);
    rd_chk(8'h29, 8'h00);
    rd_chk(8'h2a, 8'h00);
    rd_chk(8'h2b, 8'h00);
    rd_chk(8'h2c, 8'h00);
    `CHK(bios_e_decode_en_out, 1'b0)
    `CHK(parallel_mode_valid_out, 1'b1)
    `CHK(fan_pins_gpio_out, 1'b0)
    `CHK(flash_read_bytes_out, 3'h1)
    // decode disable and parallel mode codes
    wr_reg(8'h28, 8'hfb);
    rd_chk(8'h28, 8'h7b);
    `CHK(bios_e_decode_en_out, 1'b0)
    `CHK(parallel_mode_code_out, 3'h3)
    `CHK(parallel_mode_valid_out, 1'b1)
    wr_reg(8'h28, 8'h02);
    `CHK(bios_e_decode_en_out, 1'b1)
    `CHK(parallel_mode_code_out, 3'h2)
    `CHK(parallel_mode_valid_out, 1'b1)
    wr_reg(8'h27, 8'hff);
    wr_reg(8'h2b, 8'hff);
    rd_chk(8'h27, 8'h00);
    rd_chk(8'h2b, 8'h00);
    // serial A group and fan pair
    wr_reg(8'h29, 8'hff);
    rd_chk(8'h29, 8'h4e);
    `CHK(uart_a_pins_gpio_out, 1'b1)
    wr_reg(8'h29, 8'h02);
    `CHK(uart_a_pins_gpio_out, 1'b0)
    `CHK(fan_pins_gpio_out, 1'b1)
    wr_reg(8'h29, 8'h00);
    `CHK(fan_pins_gpio_out, 1'b0)
    // normal read clock codes
    for (int c = 0; c < 3; c++) begin
      wr_reg(8'h2a, {c[1:0], 6'h00});
      `CHK(flash_clk_code_out, c[1:0])
      `CHK(flash_fast_read_out, 1'b0)
      `CHK(flash_read_bytes_out, 3'h1)
    end
    wr_reg(8'h2a, 8'h30);
    `CHK(flash_fast_read_out, 1'b1)
    `CHK(flash_clk_code_out, 2'h1)
    `CHK(flash_read_bytes_out, 3'h4)
    // shared pins and keyboard/mouse group
    wr_reg(8'h2a, 8'h02);
    `CHK(i2c_pins_active_out, 1'b1)
    `CHK(reset_output_three_en_out, 1'b0)
    `CHK(reset_output_two_en_out, 1'b0)
    reset_output_three_sel_in = 1'b0;
    wr_reg(8'h2a, 8'h01);
    `CHK(i2c_pins_active_out, 1'b0)
    `CHK(reset_output_three_en_out, 1'b0)
    `CHK(reset_output_two_en_out, 1'b1)
    `CHK(kbms_pins_gpio_out, 1'b1)
    reset_output_three_sel_in = 1'b1;
    // filters: short glitch blocked, long level passes, bypass passes
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h2a, 8'h00);
      probe(s, 2, 12, hit);
      `CHK(hit, 1'b0)
      probe(s, 10, 14, hit);
      `CHK(hit, 1'b1)
      wr_reg(8'h2a, (s == 0) ? 8'h08 : 8'h04);
      probe(s, 2, 10, hit);
      `CHK(hit, 1'b1)
    end
    // lock blocks reads and writes
    wr_reg(8'h28, 8'h13);
    config_write_lock_in = 1'b1;
    wr_reg(8'h28, 8'h00);
    rd_chk(8'h28, 8'h00);
    config_write_lock_in = 1'b0;
    rd_chk(8'h28, 8'h13);
    `CHK(bios_e_decode_en_out, 1'b0)
    // wells keep their fields across other resets
    wr_reg(8'h2a, 8'h4f);
    do_reset(3'h1);
    rd_chk(8'h2a, 8'h40);
    rd_chk(8'h28, 8'h50);
    do_reset(3'h2);
    rd_chk(8'h2a, 8'h00);
    wr_reg(8'h2a, 8'h3f);
    do_reset(3'h2);
    rd_chk(8'h2a, 8'h3f);
    do_reset(3'h4);
    rd_chk(8'h2a, 8'h0f);
    finish_test();
  end
endmodule
